// ---- logic/duml_pkg.sv ----
// Shared constants and types for the dual serial channel block.
package duml_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [2:0] DUML_REG_DATA = 3'h0;
  localparam logic [2:0] DUML_REG_IER  = 3'h1;
  localparam logic [2:0] DUML_REG_ISR  = 3'h2;
  localparam logic [2:0] DUML_REG_LCR  = 3'h3;
  localparam logic [2:0] DUML_REG_MCTL = 3'h4;
  localparam logic [2:0] DUML_REG_LSR  = 3'h5;
  localparam logic [2:0] DUML_REG_MSTS = 3'h6;
  localparam logic [2:0] DUML_REG_SPR  = 3'h7;
  localparam int         DUML_CHAN_BIT = 5;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int DUML_LCR_DLAB = 7;
  localparam int DUML_LCR_BRK  = 6;
  localparam int DUML_LCR_PEN  = 3;
  localparam int DUML_LCR_STB  = 2;
  localparam int DUML_MC_DTR   = 0;
  localparam int DUML_MC_RTS   = 1;
  localparam int DUML_MC_OUT1  = 2;
  localparam int DUML_MC_IRQE  = 3;
  localparam int DUML_MC_LOOP  = 4;
  localparam int DUML_FCR_EN   = 0;
  localparam int DUML_FCR_RXR  = 1;
  localparam int DUML_FCR_TXR  = 2;

  // ==========================================================
  // Reset values, sizes and counts
  // ==========================================================
  localparam logic [7:0] DUML_CTRL_RST = 8'h00;
  localparam logic [7:0] DUML_DLL_RST  = 8'h01;
  localparam logic [5:0] DUML_DEPTH    = 6'h20;
  localparam logic [5:0] DUML_ONE      = 6'h01;
  localparam logic [3:0] DUML_OS_LAST  = 4'hf;
  localparam logic [3:0] DUML_OS_MID   = 4'h7;
  localparam logic [5:0] DUML_TRIG_8   = 6'h08;
  localparam logic [5:0] DUML_TRIG_16  = 6'h10;
  localparam logic [5:0] DUML_TRIG_24  = 6'h18;
  localparam logic [5:0] DUML_TRIG_28  = 6'h1c;
  localparam logic [3:0] DUML_ISR_LS   = 4'h6;
  localparam logic [3:0] DUML_ISR_RX   = 4'h4;
  localparam logic [3:0] DUML_ISR_TX   = 4'h2;
  localparam logic [3:0] DUML_ISR_MS   = 4'h0;
  localparam logic [3:0] DUML_ISR_NONE = 4'h1;

  typedef enum logic [2:0] {
    DUML_IDLE, DUML_START, DUML_DATA, DUML_PAR, DUML_STOP
  } duml_state_t;

endpackage : duml_pkg

// ---- logic/duml_top.sv ----
// Dual serial channel with modem lines behind an Avalon-MM slave.
// Behaviour
// RULE1: two channels, 32-byte transmit and receive FIFOs.
// RULE2: host selects exactly one channel per access.
// RULE3: start bit before data, stop bits after.
// RULE4: optional parity sent; receiver flags mismatches.
// RULE5: four FIFO trigger levels each raise interrupts.
// RULE6: rates up to 5 Mbit/s supported.
// RULE7: programmable divisor sets the data rate.
// RULE8: clear-to-send level readable at status bit 4.
// RULE9: modem lines never gate transmit or receive.
// RULE10: low set-ready means remote modem ready.
// RULE11: control bit 0 drives terminal-ready low.
// RULE12: terminal-ready output high after reset.
// RULE13: control bit 1 drives request-to-send low.
// RULE14: request-to-send output high after reset.
// RULE15: ring-indicator rising edge raises modem interrupt.
// RULE16: transmit pin high in reset, idle, disabled.
// RULE17: receive line treated idle high in reset.
// RULE18: loop-back routes transmitter into receiver internally.
// RULE19: reset defaults match legacy FIFO-less behaviour.
// RULE20: interrupt pin driven only while control bit 3.
// RULE21: three address bits pick register, strobes move data.
// RULE22: reset clears registers and disables serial pins; the divisor low byte resets to 01, not 00.
// RULE23: both channels are identical independent copies.

// ==========================================================
// One serial channel
// ==========================================================
module duml_channel
  import duml_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_fire,
  input  wire logic       rd_fire,
  input  wire logic [2:0] reg_sel,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  input  wire logic       serial_in,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  output logic            serial_out,
  output logic            terminal_ready_n,
  output logic            request_send_n,
  output logic            irq,
  output logic            irq_oe
);

  function automatic logic duml_parity(
    input logic [7:0] d,
    input logic [1:0] wl,
    input logic [5:3] pc
  );
    logic [7:0] m;
    m = d & {wl == 2'h3, wl >= 2'h2, wl >= 2'h1, 5'h1f};
    if (pc[5])
      duml_parity = ~pc[4];
    else
      duml_parity = pc[4] ? ^m : ~^m;
  endfunction : duml_parity

  function automatic logic [5:0] duml_level(input logic [1:0] sel);
    case (sel)
      2'h0:    duml_level = DUML_TRIG_8;
      2'h1:    duml_level = DUML_TRIG_16;
      2'h2:    duml_level = DUML_TRIG_24;
      default: duml_level = DUML_TRIG_28;
    endcase
  endfunction : duml_level

  logic [7:0]  ier, lcr, modem_ctl, fcr, spr, dll, dlm;
  logic [7:0]  tx_mem [0:31];
  logic [7:0]  rx_mem [0:31];
  logic [4:0]  tx_wp, tx_rp, rx_wp, rx_rp;
  logic [5:0]  tx_cnt, rx_cnt;
  logic [15:0] div_cnt;
  duml_state_t tx_state, rx_state;
  logic [3:0]  tx_os, rx_os;
  logic [2:0]  tx_idx, rx_idx;
  logic [7:0]  tx_shift, rx_shift;
  logic        tx_line, tx_par, rx_perr;
  logic        lsr_oe, lsr_pe, lsr_fe, lsr_bi;
  logic        dcts, ddsr, teri, cts_q, dsr_q, ri_q;

  // ==========================================================
  // Register decode
  // ==========================================================
  wire dlab    = lcr[DUML_LCR_DLAB];
  wire loop    = modem_ctl[DUML_MC_LOOP];
  wire at_data = reg_sel == DUML_REG_DATA;
  wire at_ier  = reg_sel == DUML_REG_IER;
  wire wr_thr  = wr_fire && at_data && !dlab;         // [RULE21]
  wire wr_dll  = wr_fire && at_data && dlab;
  wire wr_dlm  = wr_fire && at_ier && dlab;
  wire wr_ier  = wr_fire && at_ier && !dlab;
  wire wr_fcr  = wr_fire && reg_sel == DUML_REG_ISR;
  wire rd_rhr  = rd_fire && at_data && !dlab;         // [RULE21]
  wire rd_lsr  = rd_fire && reg_sel == DUML_REG_LSR;
  wire rd_msts = rd_fire && reg_sel == DUML_REG_MSTS;
  wire flush_rx = wr_fcr && (wdata[DUML_FCR_RXR]
                  || wdata[DUML_FCR_EN] != fcr[DUML_FCR_EN]);
  wire flush_tx = wr_fcr && (wdata[DUML_FCR_TXR]
                  || wdata[DUML_FCR_EN] != fcr[DUML_FCR_EN]);

  // With the FIFOs off each side holds one byte, as legacy parts do.
  wire [5:0] limit   = fcr[DUML_FCR_EN] ? DUML_DEPTH : DUML_ONE; // [RULE19]
  wire [5:0] rx_trig = fcr[DUML_FCR_EN] ? duml_level(fcr[7:6])
                       : DUML_ONE;                  // [RULE5]
  // Transmit levels are rotated so that reset selects sixteen.
  wire [5:0] tx_trig = duml_level(fcr[5:4] ^ 2'h1); // [RULE5]

  always_ff @(posedge clk) begin
    if (rst) begin                                  // [RULE22]
      ier <= DUML_CTRL_RST;
      lcr <= DUML_CTRL_RST;
      modem_ctl <= DUML_CTRL_RST;
      fcr <= DUML_CTRL_RST;
      spr <= DUML_CTRL_RST;
      dll <= DUML_DLL_RST;
      dlm <= DUML_CTRL_RST;
    end else if (wr_fire) begin
      if (wr_ier) ier <= {4'h0, wdata[3:0]};
      if (wr_dll) dll <= wdata;
      if (wr_dlm) dlm <= wdata;
      if (wr_fcr) fcr <= {wdata[7:4], 3'h0, wdata[0]};
      if (reg_sel == DUML_REG_LCR) lcr <= wdata;
      if (reg_sel == DUML_REG_MCTL) modem_ctl <= {3'h0, wdata[4:0]};
      if (reg_sel == DUML_REG_SPR) spr <= wdata;
    end
  end

  // ==========================================================
  // Baud divider, sixteen ticks per bit
  // ==========================================================
  // At 100 MHz a divisor of 1 gives 6.25 Mbit/s, so 5 Mbit/s and
  // 460.8 kbit/s are reached by choosing the divisor.
  wire [15:0] divisor  = {dlm, dll};
  wire [15:0] div_last = (divisor == 16'h0) ? 16'h0 : divisor - 16'h1;
  wire        tick     = div_cnt == div_last;       // [RULE6] [RULE7]

  always_ff @(posedge clk) begin
    if (rst || tick)
      div_cnt <= 16'h0;
    else
      div_cnt <= div_cnt + 16'h1;
  end

  // ==========================================================
  // FIFOs
  // ==========================================================
  // Modem inputs are not consulted before starting a character.
  wire tx_pop  = tick && tx_state == DUML_IDLE && tx_cnt != 6'h0; // [RULE9]
  wire tx_push = wr_thr && tx_cnt < limit;          // [RULE1]
  wire rx_done = tick && rx_state == DUML_STOP && rx_os == DUML_OS_LAST;
  wire rx_push = rx_done && rx_cnt < limit;         // [RULE1]
  wire rx_pop  = rd_rhr && rx_cnt != 6'h0;
  wire [5:0] next_tx_cnt = tx_cnt + {5'h0, tx_push} - {5'h0, tx_pop};
  wire [5:0] next_rx_cnt = rx_cnt + {5'h0, rx_push} - {5'h0, rx_pop};

  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp] <= wdata;
    if (rx_push) rx_mem[rx_wp] <= rx_shift;
  end

  always_ff @(posedge clk) begin
    if (rst || flush_tx) begin
      tx_wp  <= 5'h0;
      tx_rp  <= 5'h0;
      tx_cnt <= 6'h0;
    end else begin
      tx_wp  <= tx_wp + {4'h0, tx_push};
      tx_rp  <= tx_rp + {4'h0, tx_pop};
      tx_cnt <= next_tx_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush_rx) begin
      rx_wp  <= 5'h0;
      rx_rp  <= 5'h0;
      rx_cnt <= 6'h0;
    end else begin
      rx_wp  <= rx_wp + {4'h0, rx_push};
      rx_rp  <= rx_rp + {4'h0, rx_pop};
      rx_cnt <= next_rx_cnt;
    end
  end

  // ==========================================================
  // Transmitter
  // ==========================================================
  wire os_end_tx = tx_os == DUML_OS_LAST;
  wire last_bit  = {1'b0, tx_idx} == {2'h0, lcr[1:0]} + 4'h4;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state <= DUML_IDLE;
      tx_os    <= 4'h0;
      tx_idx   <= 3'h0;
      tx_shift <= 8'h0;
      tx_par   <= 1'b0;
      tx_line  <= 1'b1;
    end else if (tick) begin
      tx_os <= (tx_state == DUML_IDLE) ? 4'h0 : tx_os + 4'h1;
      case (tx_state)
        DUML_IDLE: if (tx_pop) begin
          tx_shift <= tx_mem[tx_rp];
          tx_par   <= duml_parity(tx_mem[tx_rp], lcr[1:0], lcr[5:3]);
          tx_line  <= 1'b0;                         // [RULE3]
          tx_state <= DUML_START;
        end
        DUML_START: if (os_end_tx) begin
          tx_idx   <= 3'h0;
          tx_line  <= tx_shift[0];
          tx_state <= DUML_DATA;
        end
        DUML_DATA: if (os_end_tx) begin
          tx_shift <= tx_shift >> 1;
          tx_idx   <= tx_idx + 3'h1;
          if (!last_bit)
            tx_line <= tx_shift[1];
          else if (lcr[DUML_LCR_PEN]) begin
            tx_line  <= tx_par;                     // [RULE4]
            tx_state <= DUML_PAR;
          end else begin
            tx_line  <= 1'b1;                       // [RULE3]
            tx_idx   <= 3'h0;
            tx_state <= DUML_STOP;
          end
        end
        DUML_PAR: if (os_end_tx) begin
          tx_line  <= 1'b1;
          tx_idx   <= 3'h0;
          tx_state <= DUML_STOP;
        end
        default: if (os_end_tx) begin
          // One and a half stop bits are sent as two.
          if (lcr[DUML_LCR_STB] && tx_idx == 3'h0)
            tx_idx <= 3'h1;
          else
            tx_state <= DUML_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Receiver
  // ==========================================================
  wire rx_line   = loop ? tx_line : serial_in;      // [RULE18] [RULE17]
  wire os_end_rx = rx_os == DUML_OS_LAST;
  wire rx_last   = {1'b0, rx_idx} == {2'h0, lcr[1:0]} + 4'h4;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state <= DUML_IDLE;
      rx_os    <= 4'h0;
      rx_idx   <= 3'h0;
      rx_shift <= 8'h0;
      rx_perr  <= 1'b0;
    end else if (tick) begin
      rx_os <= rx_os + 4'h1;
      case (rx_state)
        DUML_IDLE: begin
          rx_os <= 4'h0;
          if (!rx_line) rx_state <= DUML_START;
        end
        // A start bit that is gone at mid-bit is noise.
        DUML_START: if (rx_os == DUML_OS_MID) begin
          rx_os    <= 4'h0;
          rx_idx   <= 3'h0;
          rx_shift <= 8'h0;
          rx_perr  <= 1'b0;
          rx_state <= rx_line ? DUML_IDLE : DUML_DATA; // [RULE3]
        end
        DUML_DATA: if (os_end_rx) begin
          rx_shift[rx_idx] <= rx_line;
          rx_idx <= rx_idx + 3'h1;
          if (rx_last)
            rx_state <= lcr[DUML_LCR_PEN] ? DUML_PAR : DUML_STOP;
        end
        DUML_PAR: if (os_end_rx) begin
          rx_perr  <= rx_line != duml_parity(rx_shift, lcr[1:0],
                                             lcr[5:3]); // [RULE4]
          rx_state <= DUML_STOP;
        end
        default: if (os_end_rx) rx_state <= DUML_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Line and modem status
  // ==========================================================
  wire set_oe = rx_done && rx_cnt >= limit;
  wire set_pe = rx_done && rx_perr;                 // [RULE4]
  wire set_fe = rx_done && !rx_line;
  wire set_bi = set_fe && rx_shift == 8'h0;
  wire cts_e  = loop ? ~modem_ctl[DUML_MC_RTS] : cts_n;
  wire dsr_e  = loop ? ~modem_ctl[DUML_MC_DTR] : dsr_n;  // [RULE10]
  wire ri_e   = loop ? ~modem_ctl[DUML_MC_OUT1] : ri_n;
  wire ri_rise = !ri_q && ri_e;                     // [RULE15]

  // A status event in the clearing read's cycle is kept.
  always_ff @(posedge clk) begin
    if (rst) begin
      lsr_oe <= 1'b0;
      lsr_pe <= 1'b0;
      lsr_fe <= 1'b0;
      lsr_bi <= 1'b0;
      dcts   <= 1'b0;
      ddsr   <= 1'b0;
      teri   <= 1'b0;
      cts_q  <= 1'b1;
      dsr_q  <= 1'b1;
      ri_q   <= 1'b1;
    end else begin
      lsr_oe <= (lsr_oe && !rd_lsr) || set_oe;
      lsr_pe <= (lsr_pe && !rd_lsr) || set_pe;
      lsr_fe <= (lsr_fe && !rd_lsr) || set_fe;
      lsr_bi <= (lsr_bi && !rd_lsr) || set_bi;
      dcts   <= (dcts && !rd_msts) || cts_q != cts_e;
      ddsr   <= (ddsr && !rd_msts) || dsr_q != dsr_e;
      teri   <= (teri && !rd_msts) || ri_rise;      // [RULE15]
      cts_q  <= cts_e;
      dsr_q  <= dsr_e;
      ri_q   <= ri_e;
    end
  end

  // ==========================================================
  // Interrupt sources
  // ==========================================================
  wire [5:0] tx_free = DUML_DEPTH - tx_cnt;
  wire int_ls = ier[2] && (lsr_oe || lsr_pe || lsr_fe || lsr_bi);
  wire int_rx = ier[0] && rx_cnt >= rx_trig;        // [RULE5]
  wire int_tx = ier[1] && (fcr[DUML_FCR_EN] ? tx_free >= tx_trig
                                            : tx_cnt == 6'h0);
  wire int_ms = ier[3] && (dcts || ddsr || teri);   // [RULE15]
  wire [3:0] isr_code = int_ls ? DUML_ISR_LS :
                        int_rx ? DUML_ISR_RX :
                        int_tx ? DUML_ISR_TX :
                        int_ms ? DUML_ISR_MS : DUML_ISR_NONE;
  wire tx_empty = tx_cnt == 6'h0;
  wire [7:0] lsr = {1'b0, tx_empty && tx_state == DUML_IDLE, tx_empty,
                    lsr_bi, lsr_fe, lsr_pe, lsr_oe, rx_cnt != 6'h0};
  wire [7:0] modem_sts = {1'b0, ~ri_e, ~dsr_e, ~cts_e,
                          1'b0, teri, ddsr, dcts};  // [RULE8]

  always_comb begin
    if (reg_sel == DUML_REG_DATA)
      rdata = dlab ? dll : rx_mem[rx_rp];
    else if (reg_sel == DUML_REG_IER)
      rdata = dlab ? dlm : ier;
    else if (reg_sel == DUML_REG_ISR)
      rdata = {{2{fcr[DUML_FCR_EN]}}, 2'h0, isr_code};
    else if (reg_sel == DUML_REG_LCR)
      rdata = lcr;
    else if (reg_sel == DUML_REG_MCTL)
      rdata = modem_ctl;
    else if (reg_sel == DUML_REG_LSR)
      rdata = lsr;
    else if (reg_sel == DUML_REG_MSTS)
      rdata = modem_sts;
    else
      rdata = spr;
  end

  // ==========================================================
  // Pins
  // ==========================================================
  // In loop-back the modem outputs go inactive and the pin idles.
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_out       <= 1'b1;                     // [RULE16] [RULE22]
      terminal_ready_n <= 1'b1;                     // [RULE12]
      request_send_n   <= 1'b1;                     // [RULE14]
      irq              <= 1'b0;
      irq_oe           <= 1'b0;
    end else begin
      serial_out <= loop || (tx_line && !lcr[DUML_LCR_BRK]); // [RULE18]
      terminal_ready_n <= loop || !modem_ctl[DUML_MC_DTR]; // [RULE11]
      request_send_n   <= loop || !modem_ctl[DUML_MC_RTS]; // [RULE13]
      irq              <= isr_code != DUML_ISR_NONE;
      irq_oe           <= modem_ctl[DUML_MC_IRQE];  // [RULE20]
    end
  end

endmodule : duml_channel

// ==========================================================
// Top: Avalon-MM slave and two channels
// ==========================================================
module duml_top
  import duml_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        SERIAL_IN_A,
  input  wire logic        SERIAL_IN_B,
  input  wire logic        CLEAR_TO_SEND_IN_A_N,
  input  wire logic        CLEAR_TO_SEND_IN_B_N,
  input  wire logic        SET_READY_IN_A_N,
  input  wire logic        SET_READY_IN_B_N,
  input  wire logic        RING_INDICATOR_A_N,
  input  wire logic        RING_INDICATOR_B_N,
  output logic             SERIAL_OUT_A,
  output logic             SERIAL_OUT_B,
  output logic             TERMINAL_READY_OUT_A_N,
  output logic             TERMINAL_READY_OUT_B_N,
  output logic             REQUEST_SEND_OUT_A_N,
  output logic             REQUEST_SEND_OUT_B_N,
  output logic             IRQ_OUT_A,
  output logic             IRQ_OUT_A_OE,
  output logic             IRQ_OUT_B,
  output logic             IRQ_OUT_B_OE
);

  logic [7:0] rdata_a, rdata_b;

  // Every access waits one cycle, which is when read data settle.
  wire accept  = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  wire chan_b  = AVS_ADDRESS[DUML_CHAN_BIT];        // [RULE2]
  wire wr_ok   = accept && AVS_WRITE && AVS_BYTEENABLE[0];
  // Reads act at the capture edge, so no flag is cleared unseen.
  wire rd_ok   = AVS_READ && AVS_WAITREQUEST;
  wire [2:0] reg_sel = AVS_ADDRESS[4:2];            // [RULE21]
  wire [7:0] rsel = chan_b ? rdata_b : rdata_a;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST)
        AVS_READDATA <= {24'h0, rsel};
    end
  end

  duml_channel u_chan_a (                           // [RULE23]
    .clk              (SYS_CLK),
    .rst              (SYS_RST),
    .wr_fire          (wr_ok && !chan_b),
    .rd_fire          (rd_ok && !chan_b),
    .reg_sel          (reg_sel),
    .wdata            (AVS_WRITEDATA[7:0]),
    .rdata            (rdata_a),
    .serial_in        (SERIAL_IN_A),
    .cts_n            (CLEAR_TO_SEND_IN_A_N),
    .dsr_n            (SET_READY_IN_A_N),
    .ri_n             (RING_INDICATOR_A_N),
    .serial_out       (SERIAL_OUT_A),
    .terminal_ready_n (TERMINAL_READY_OUT_A_N),
    .request_send_n   (REQUEST_SEND_OUT_A_N),
    .irq              (IRQ_OUT_A),
    .irq_oe           (IRQ_OUT_A_OE)
  );

  duml_channel u_chan_b (                           // [RULE23]
    .clk              (SYS_CLK),
    .rst              (SYS_RST),
    .wr_fire          (wr_ok && chan_b),
    .rd_fire          (rd_ok && chan_b),
    .reg_sel          (reg_sel),
    .wdata            (AVS_WRITEDATA[7:0]),
    .rdata            (rdata_b),
    .serial_in        (SERIAL_IN_B),
    .cts_n            (CLEAR_TO_SEND_IN_B_N),
    .dsr_n            (SET_READY_IN_B_N),
    .ri_n             (RING_INDICATOR_B_N),
    .serial_out       (SERIAL_OUT_B),
    .terminal_ready_n (TERMINAL_READY_OUT_B_N),
    .request_send_n   (REQUEST_SEND_OUT_B_N),
    .irq              (IRQ_OUT_B),
    .irq_oe           (IRQ_OUT_B_OE)
  );

endmodule : duml_top

// ---- test/duml_far_end.sv ----
// Null-modem far end: crosses the serial lines, drives modem inputs.
module duml_far_end (
  input  wire logic       tx_a,
  input  wire logic       tx_b,
  input  wire logic [5:0] ctl,
  output logic            rx_a,
  output logic            rx_b,
  output logic      [5:0] modem_n
);
  // ==========================================================
  // Wiring
  // ==========================================================
  // The cable has no delay, so a quiet transmitter reads as idle high.
  assign rx_a    = tx_b;
  assign rx_b    = tx_a;
  // Modem lines are plain levels and never wait on serial traffic.
  assign modem_n = ctl;
endmodule : duml_far_end

// ---- test/duml_props.sv ----
// Checker of bus handshake and pin behaviour for the dual channel.
module duml_props (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        SERIAL_OUT_A,
  input wire logic        SERIAL_OUT_B,
  input wire logic        TERMINAL_READY_OUT_A_N,
  input wire logic        TERMINAL_READY_OUT_B_N,
  input wire logic        REQUEST_SEND_OUT_A_N,
  input wire logic        REQUEST_SEND_OUT_B_N,
  input wire logic        IRQ_OUT_A_OE,
  input wire logic        IRQ_OUT_B_OE
);
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // A bit must stay stable for eight more clocks after it changes, even at the fastest divisor.
  sequence s_bit_hold;
    $stable(SERIAL_OUT_A) [*8];
  endsequence
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low for more than one cycle");
  a_wait_cause: assert property ($fell(AVS_WAITREQUEST) |->
    $past(AVS_READ) || $past(AVS_WRITE)) else $error("answer without request");
  a_read_upper: assert property (AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_tx: assert property ($fell(SYS_RST) |->
    SERIAL_OUT_A && SERIAL_OUT_B) else $error("transmit low after reset");
  a_reset_modem: assert property ($fell(SYS_RST) |->
    TERMINAL_READY_OUT_A_N && TERMINAL_READY_OUT_B_N &&
    REQUEST_SEND_OUT_A_N && REQUEST_SEND_OUT_B_N)
    else $error("modem outputs active after reset");
  a_reset_irq: assert property ($fell(SYS_RST) |->
    !IRQ_OUT_A_OE && !IRQ_OUT_B_OE) else $error("irq driven after reset");
  a_reset_wait: assert property ($fell(SYS_RST) |->
    AVS_WAITREQUEST [*2]) else $error("wait low right after reset");
  a_tx_hold: assert property ($changed(SERIAL_OUT_A) |=> s_bit_hold)
    else $error("serial bit too short");
endmodule : duml_props

bind duml_top duml_props u_props (.SYS_CLK, .SYS_RST, .AVS_READ,
  .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .SERIAL_OUT_A,
  .SERIAL_OUT_B, .TERMINAL_READY_OUT_A_N, .TERMINAL_READY_OUT_B_N,
  .REQUEST_SEND_OUT_A_N, .REQUEST_SEND_OUT_B_N, .IRQ_OUT_A_OE,
  .IRQ_OUT_B_OE);

// ---- test/testbench.sv ----
// Self-checking bench for the dual serial channel block.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals and instances
  // ==========================================================
  logic clk = 0, rst = 1, rd = 0, wr = 0;
  logic [5:0] adr = 6'h00, ctl = 6'h3f, mdm;
  logic [31:0] wd = 32'h0, rdv, rdata;
  logic [3:0] be = 4'hf;
  logic wq, irqa, oea, irqb, oeb;
  logic so_a, so_b, si_a, si_b, tr_a, tr_b, rq_a, rq_b;
  int fails = 0, checked = 0;
  initial forever #5 clk = ~clk;
  duml_top u_dut (.SYS_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
    .SERIAL_IN_A(si_a), .SERIAL_IN_B(si_b), .CLEAR_TO_SEND_IN_A_N(mdm[0]),
    .CLEAR_TO_SEND_IN_B_N(mdm[1]), .SET_READY_IN_A_N(mdm[2]),
    .SET_READY_IN_B_N(mdm[3]), .RING_INDICATOR_A_N(mdm[4]),
    .RING_INDICATOR_B_N(mdm[5]), .SERIAL_OUT_A(so_a), .SERIAL_OUT_B(so_b),
    .TERMINAL_READY_OUT_A_N(tr_a), .TERMINAL_READY_OUT_B_N(tr_b),
    .REQUEST_SEND_OUT_A_N(rq_a), .REQUEST_SEND_OUT_B_N(rq_b),
    .IRQ_OUT_A(irqa), .IRQ_OUT_A_OE(oea), .IRQ_OUT_B(irqb),
    .IRQ_OUT_B_OE(oeb));
  duml_far_end u_far (.tx_a(so_a), .tx_b(so_b), .ctl(ctl), .rx_a(si_a),
    .rx_b(si_b), .modem_n(mdm));
  // ==========================================================
  // Tasks and expectations
  // ==========================================================
  function automatic logic [2:0] exp_ctl(input logic [7:0] v);
    return {~v[0], ~v[1], v[3]};
  endfunction : exp_ctl
  function automatic logic [3:0] exp_sts(input logic [5:0] m);
    return {1'b0, ~m[4], ~m[2], ~m[0]};
  endfunction : exp_sts
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do begin @(posedge clk); n++; end while (wq !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rdv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : xfer
  task automatic wait_rx(input logic [5:0] a);
    int n;
    n = 0;
    do begin xfer(0, a, 8'h0); n++; end while (rdv[0] !== 1'b1 && n < 80);
    if (rdv[0] !== 1'b1) fails++;
  endtask : wait_rx
  task automatic send(input logic [7:0] la, lb, input logic pe);
    logic [7:0] c, ls;
    c = 8'($urandom);
    xfer(1, 6'h0c, la);
    xfer(1, 6'h2c, lb);
    xfer(1, 6'h00, c);
    wait_rx(6'h34);
    ls = rdv[7:0];
    xfer(0, 6'h20, 8'h0);
    `CHK(rdv[7:0], c)
    `CHK(ls[2], pe)
  endtask : send
  task automatic modem_set(input logic [7:0] v);
    xfer(1, 6'h10, v & 8'h0f);
    xfer(1, 6'h30, ~v & 8'h0f);
    @(posedge clk);
    #1;
    `CHK({tr_a, rq_a, oea}, exp_ctl(v))
    `CHK({tr_b, rq_b, oeb}, exp_ctl(~v))
  endtask : modem_set
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    rdv = $urandom(44);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({so_a, so_b}, 2'h3)
    `CHK({tr_a, tr_b, rq_a, rq_b, oea, oeb}, 6'h3c)
    xfer(0, 6'h10, 8'h0);
    `CHK(rdv[7:0], 8'h00)
    repeat (4) modem_set(8'($urandom));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) ctl <= 6'($urandom) | 6'h30;
      repeat (3) @(posedge clk);
      xfer(0, 6'h18, 8'h0);
      `CHK(rdv[7:4], exp_sts(ctl))
      xfer(0, 6'h38, 8'h0);
      `CHK(rdv[6:4], ~{ctl[5], ctl[3], ctl[1]})
    end
    @(posedge clk) ctl[4] <= 1'b0;
    repeat (3) @(posedge clk);
    xfer(0, 6'h18, 8'h0);
    xfer(1, 6'h04, 8'h08);
    @(posedge clk) ctl[4] <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({irqa, irqb}, 2'b10)
    xfer(0, 6'h18, 8'h0);
    `CHK(rdv[2], 1'b1)
    send(8'h03, 8'h03, 1'b0);
    send(8'h0b, 8'h0b, 1'b0);
    send(8'h1b, 8'h0b, 1'b1);
    xfer(1, 6'h10, 8'h13);
    xfer(1, 6'h00, 8'h5a);
    wait_rx(6'h14);
    `CHK({so_a, tr_a, rq_a}, 3'b111)
    xfer(0, 6'h00, 8'h0);
    `CHK(rdv[7:0], 8'h5a)
    xfer(0, 6'h34, 8'h0);
    `CHK(rdv[0], 1'b0)
    xfer(1, 6'h08, 8'h01);
    for (int i = 0; i < 3; i++) xfer(1, 6'h00, 8'h30 + 8'(i));
    repeat (700) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      xfer(0, 6'h00, 8'h0);
      `CHK(rdv[7:0], 8'h30 + 8'(i))
    end
    // A second reset in mid-run must clear the modem control register of channel A.
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    xfer(0, 6'h10, 8'h0);
    `CHK(rdv[7:0], 8'h00)
    wrap_up;
  end
  initial begin
    #300000;
    fails++;
    wrap_up;
  end
endmodule : testbench
